/* File: hw/pirfb_pkg.sv */
package pirfb_pkg;
	// register byte addresses on the AHB-Lite bus
	localparam logic [7:0] FLAGS_A_ADDR  = 8'h00;
	localparam logic [7:0] FLAGS_B_ADDR  = 8'h04;
	localparam logic [7:0] ENABLE_A_ADDR = 8'h08;
	localparam logic [7:0] ENABLE_B_ADDR = 8'h0C;
	localparam logic [7:0] RX_DATA_ADDR  = 8'h10;
	localparam logic [7:0] TX_DATA_ADDR  = 8'h14;
	localparam logic [7:0] POWER_CTL_ADDR = 8'h18;
	localparam logic [7:0] RESET_CAUSE_ADDR = 8'h1C;

	// flag register a bit positions
	localparam int A_WIDE_TMR = 0;
	localparam int A_PERIOD   = 1;
	localparam int A_CAPCMP   = 2;
	localparam int A_SYNC     = 3;
	localparam int A_TX       = 4;
	localparam int A_RX       = 5;
	// flag register b bit positions
	localparam int B_CAPCMP   = 0;
	localparam int B_UNUSED   = 1;
	localparam int B_WAKE     = 2;
	localparam int B_COLL     = 3;
	localparam int B_NVWR     = 4;
	localparam int B_CMPA     = 5;
	localparam int B_CMPB     = 6;
	localparam int B_OSC      = 7;

	// software-writable flag masks
	localparam logic [7:0] A_SW_MASK = 8'h0F;
	localparam logic [7:0] B_SW_MASK = 8'hFD;
	localparam logic [7:0] FLAGS_RESET = 8'h00;

	// power control bit positions and reset
	localparam int PC_WAKE_EN = 5;
	localparam int PC_BOR_EN  = 4;
	localparam logic [7:0] POWER_CTL_RESET = 8'h10;
	localparam logic [7:0] POWER_CTL_MASK  = 8'h30;

	// reset cause bit positions (1 = that reset occurred)
	localparam int RC_POR  = 0;
	localparam int RC_BOR  = 1;
	localparam int RC_WDT  = 2;
	localparam int RC_PIN  = 3;
	localparam logic [3:0] RC_MASK = 4'hF;

	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

	typedef enum logic [1:0] {
		PIRFB_CC_OFF     = 2'b00,
		PIRFB_CC_CAPTURE = 2'b01,
		PIRFB_CC_COMPARE = 2'b11,
		PIRFB_CC_PWM     = 2'b10
	} pirfb_ccmode_e;

	// peripheral events, one-cycle pulses except the buffer levels
	typedef struct packed {
		logic wide_tmr_ovf;
		logic period_match;
		logic capa_capture;
		logic capa_match;
		logic capb_capture;
		logic capb_match;
		logic sync_xfer_done;
		logic i2c_seq_done;
		logic i2c_idle_startstop;
		logic osc_failover;
		logic nv_write_done;
		logic bus_collision;
		logic wake_event;
		logic rx_buf_full;
		logic tx_buf_empty;
	} pirfb_events_s;

	typedef struct packed {
		logic por;
		logic bor;
		logic wdt;
		logic pin;
	} pirfb_rcause_s;
endpackage : pirfb_pkg

/* File: hw/pirfb_edge.sv */
`timescale 1ns/1ns
// flags a change of an asynchronous level after two-stage sync
module pirfb_edge
	import pirfb_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic level_in,
	output logic      changed
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} pirfb_edge_s;

	pirfb_edge_s st;
	pirfb_edge_s next_st;

	always_comb begin
		next_st    = st;
		next_st.s1 = level_in;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// s1 feeds only s2; compare settled stages
	assign changed = st.s2 ^ st.s3;
endmodule : pirfb_edge

/* File: hw/pirfb_bank.sv */
`timescale 1ns/1ns
// Summary of operation
// [RULE1] flags set regardless of any enable
// [RULE2] software clears flags before enabling interrupts
// [RULE3] rx flag follows buffer, cleared by read
// [RULE4] tx flag follows empty, cleared by write
// [RULE5] sync port flag set on event, software clears
// [RULE6] i2c master sequence completion sets sync flag
// [RULE7] idle start or stop sets sync flag
// [RULE8] capture sets unit flag, software clears
// [RULE9] compare match sets unit flag, sticky
// [RULE10] period timer match sets flag, sticky
// [RULE11] wide timer overflow sets flag, sticky
// [RULE12] oscillator failover sets flag, software clears
// [RULE13] comparator b change sets flag, sticky
// [RULE14] comparator a change sets flag, sticky
// [RULE15] nv write completion sets flag
// [RULE16] i2c master collision sets flag
// [RULE17] wake-up condition sets flag, sticky
// [RULE18] bit one reads zero; pwm leaves unused
// [RULE19] reset cause flags and power controls kept
// [RULE20] request when flag and enable both set
module pirfb_bank
	import pirfb_pkg::*;
(
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic          hsel,
	input  wire logic [31:0]   haddr,
	input  wire logic [1:0]    htrans,
	input  wire logic          hwrite,
	input  wire logic [2:0]    hsize,
	input  wire logic [31:0]   hwdata,
	input  wire logic          hready,
	output logic      [31:0]   hrdata,
	output logic               hreadyout,
	output logic               hresp,
	input  wire pirfb_events_s events,
	input  wire pirfb_ccmode_e capa_mode,
	input  wire pirfb_ccmode_e capb_mode,
	input  wire logic          comparator_a_output,
	input  wire logic          comparator_b_output,
	input  wire pirfb_rcause_s reset_cause_in,
	input  wire logic [7:0]    rx_data_in,
	output logic               rx_data_read,
	output logic               tx_data_write,
	output logic      [7:0]    tx_data_out,
	output logic               low_power_wake_enable,
	output logic               soft_brownout_enable,
	output logic               peripheral_irq_req
);
	typedef struct packed {
		logic          dp_valid;
		logic          dp_write;
		logic [7:0]    dp_addr;
		logic [31:0]   rdata;
		logic [7:0]    flags_a;
		logic [7:0]    flags_b;
		logic [7:0]    enable_a;
		logic [7:0]    enable_b;
		logic [7:0]    power_ctl;
		logic [3:0]    rcause;
		logic          rcause_armed;
		logic [7:0]    tx_data;
		logic          rx_rd;
		logic          tx_wr;
		logic          irq;
	} pirfb_state_s;

	pirfb_state_s st;
	pirfb_state_s next_st;
	logic         cmpa_chg;
	logic         cmpb_chg;
	logic [7:0]   set_a;
	logic [7:0]   set_b;
	logic [7:0]   flags_a_view;
	logic         addr_phase;

	pirfb_edge u_cmpa (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.level_in (comparator_a_output),
		.changed  (cmpa_chg)
	);
	pirfb_edge u_cmpb (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.level_in (comparator_b_output),
		.changed  (cmpb_chg)
	);

	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

	// live buffer levels override stored bits in the read view
	always_comb begin
		flags_a_view        = st.flags_a & A_SW_MASK;
		flags_a_view[A_RX]  = events.rx_buf_full;  // [RULE3]
		flags_a_view[A_TX]  = events.tx_buf_empty; // [RULE4]
	end

	// event set vectors, independent of any enable [RULE1]
	always_comb begin
		set_a              = '0;
		set_a[A_WIDE_TMR]  = events.wide_tmr_ovf;               // [RULE11]
		set_a[A_PERIOD]    = events.period_match;               // [RULE10]
		set_a[A_CAPCMP]    = (capa_mode == PIRFB_CC_CAPTURE && events.capa_capture) // [RULE8]
			|| (capa_mode == PIRFB_CC_COMPARE && events.capa_match);             // [RULE9]
		set_a[A_SYNC]      = events.sync_xfer_done              // [RULE5]
			|| events.i2c_seq_done                              // [RULE6]
			|| events.i2c_idle_startstop;                       // [RULE7]
		set_b              = '0;
		set_b[B_CAPCMP]    = (capb_mode == PIRFB_CC_CAPTURE && events.capb_capture) // [RULE8]
			|| (capb_mode == PIRFB_CC_COMPARE && events.capb_match);             // [RULE9] [RULE18]
		set_b[B_WAKE]      = events.wake_event;                 // [RULE17]
		set_b[B_COLL]      = events.bus_collision;              // [RULE16]
		set_b[B_NVWR]      = events.nv_write_done;              // [RULE15]
		set_b[B_CMPA]      = cmpa_chg;                          // [RULE14]
		set_b[B_CMPB]      = cmpb_chg;                          // [RULE13]
		set_b[B_OSC]       = events.osc_failover;               // [RULE12]
	end

	always_comb begin
		next_st       = st;
		next_st.rx_rd = 1'b0;
		next_st.tx_wr = 1'b0;
		if (hready) begin
			next_st.dp_valid = addr_phase;
			next_st.dp_write = hwrite;
			next_st.dp_addr  = haddr[7:0];
		end
		// data phase write; software may set or clear flags
		if (st.dp_valid && st.dp_write) begin
			if (st.dp_addr == FLAGS_A_ADDR) begin
				next_st.flags_a = hwdata[7:0] & A_SW_MASK;
			end else if (st.dp_addr == FLAGS_B_ADDR) begin
				next_st.flags_b = hwdata[7:0] & B_SW_MASK; // [RULE18]
			end else if (st.dp_addr == ENABLE_A_ADDR) begin
				next_st.enable_a = hwdata[7:0];
			end else if (st.dp_addr == ENABLE_B_ADDR) begin
				next_st.enable_b = hwdata[7:0] & B_SW_MASK;
			end else if (st.dp_addr == TX_DATA_ADDR) begin
				next_st.tx_data = hwdata[7:0];
				next_st.tx_wr   = 1'b1; // [RULE4]
			end else if (st.dp_addr == POWER_CTL_ADDR) begin
				next_st.power_ctl = hwdata[7:0] & POWER_CTL_MASK; // [RULE19]
			end else if (st.dp_addr == RESET_CAUSE_ADDR) begin
				// writing 1 acknowledges a cause
				next_st.rcause = st.rcause & ~(hwdata[3:0] & RC_MASK); // [RULE19]
			end
		end
		// latch the reset cause once after release
		if (!st.rcause_armed) begin
			next_st.rcause_armed = 1'b1;
			// the struct lists causes msb first, so map each one to its register bit
			next_st.rcause[RC_POR] = reset_cause_in.por; // [RULE19]
			next_st.rcause[RC_BOR] = reset_cause_in.bor;
			next_st.rcause[RC_WDT] = reset_cause_in.wdt;
			next_st.rcause[RC_PIN] = reset_cause_in.pin;
		end
		// sets win over a same-cycle software clear [RULE1]
		next_st.flags_a = next_st.flags_a | set_a;
		next_st.flags_b = (next_st.flags_b | set_b) & B_SW_MASK;
		// read data captured in address phase, presented in data phase
		next_st.rdata = '0;
		if (addr_phase && !hwrite) begin
			if (haddr[7:0] == FLAGS_A_ADDR) begin
				next_st.rdata[7:0] = flags_a_view;
			end else if (haddr[7:0] == FLAGS_B_ADDR) begin
				next_st.rdata[7:0] = st.flags_b & B_SW_MASK; // [RULE18]
			end else if (haddr[7:0] == ENABLE_A_ADDR) begin
				next_st.rdata[7:0] = st.enable_a;
			end else if (haddr[7:0] == ENABLE_B_ADDR) begin
				next_st.rdata[7:0] = st.enable_b;
			end else if (haddr[7:0] == RX_DATA_ADDR) begin
				next_st.rdata[7:0] = rx_data_in;
				next_st.rx_rd      = 1'b1; // [RULE3]
			end else if (haddr[7:0] == TX_DATA_ADDR) begin
				next_st.rdata[7:0] = st.tx_data;
			end else if (haddr[7:0] == POWER_CTL_ADDR) begin
				next_st.rdata[7:0] = st.power_ctl;
			end else if (haddr[7:0] == RESET_CAUSE_ADDR) begin
				next_st.rdata[3:0] = st.rcause;
			end
		end
		// combined request from updated flags [RULE20]
		// stored bits from next state so a cleared flag drops the request at once
		next_st.irq = |(((next_st.flags_a & A_SW_MASK) | (flags_a_view & ~A_SW_MASK)) & st.enable_a)
			|| |(next_st.flags_b & st.enable_b);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st           <= '0;
			st.power_ctl <= POWER_CTL_RESET;
			st.flags_a   <= FLAGS_RESET; // [RULE20]
			st.flags_b   <= FLAGS_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign hrdata                = st.rdata;
	assign hreadyout             = 1'b1;
	assign hresp                 = 1'b0;
	assign rx_data_read          = st.rx_rd;
	assign tx_data_write         = st.tx_wr;
	assign tx_data_out           = st.tx_data;
	assign low_power_wake_enable = st.power_ctl[PC_WAKE_EN];
	assign soft_brownout_enable  = st.power_ctl[PC_BOR_EN];
	assign peripheral_irq_req    = st.irq;

	AST_WIDE_TMR_SET: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE11]
		events.wide_tmr_ovf |=> st.flags_a[A_WIDE_TMR]) else $error("overflow flag not set");
	AST_PERIOD_SET: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE10]
		events.period_match |=> st.flags_a[A_PERIOD]) else $error("period flag not set");
	AST_SYNC_SET: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE5]
		(events.sync_xfer_done || events.i2c_seq_done || events.i2c_idle_startstop)
		|=> st.flags_a[A_SYNC]) else $error("sync flag not set");
	AST_CAPA_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE8]
		(capa_mode == PIRFB_CC_CAPTURE && events.capa_capture) |=> st.flags_a[A_CAPCMP])
		else $error("capture flag not set");
	AST_CAPB_PWM: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE18]
		(capb_mode == PIRFB_CC_PWM && !st.flags_b[B_CAPCMP] && !(st.dp_valid && st.dp_write))
		|=> !st.flags_b[B_CAPCMP]) else $error("pwm mode set unit b flag");
	AST_UNUSED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE18]
		!st.flags_b[B_UNUSED]) else $error("unimplemented bit set");
	AST_OSC_STICKY: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE12]
		(st.flags_b[B_OSC] && !(st.dp_valid && st.dp_write)) |=> st.flags_b[B_OSC])
		else $error("osc flag dropped without write");
	AST_CMPA_CHANGE: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE14]
		cmpa_chg |=> st.flags_b[B_CMPA]) else $error("comparator a flag not set");
	AST_RX_READ: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE3]
		(addr_phase && !hwrite && haddr[7:0] == RX_DATA_ADDR) |=> rx_data_read)
		else $error("rx read strobe missing");
	AST_IRQ_GATE: assert property (@(posedge core_clk) disable iff (!rst_n) // [RULE20]
		((st.flags_b & st.enable_b) != 8'h00 && $stable(st.enable_b) && $stable(st.flags_b))
		|-> peripheral_irq_req) else $error("request missing");

	COV_IRQ: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(peripheral_irq_req));
	COV_TX_WRITE: cover property (@(posedge core_clk) disable iff (!rst_n) tx_data_write);
	COV_SET_CLEAR: cover property (@(posedge core_clk) disable iff (!rst_n)
		st.dp_valid && st.dp_write && st.dp_addr == FLAGS_B_ADDR && set_b != 8'h00);
endmodule : pirfb_bank

/* File: tb/pirfb_periph.sv */
`timescale 1ns/1ns
// peripheral side: pulses events on request and models the serial buffer levels
module pirfb_periph
	import pirfb_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [14:2] fire,
	input  wire logic        rx_arrive,
	input  wire logic        rx_data_read,
	input  wire logic        tx_data_write,
	output pirfb_events_s    events
);
	logic       rx_full;
	logic [4:0] tx_busy;
	// the shifter stays busy a while so that software can see the empty flag low
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rx_full <= 1'b0;
			tx_busy <= 5'h00;
		end else begin
			rx_full <= rx_arrive | (rx_full & ~rx_data_read);
			tx_busy <= tx_data_write ? 5'h10 : tx_busy - {4'h0, |tx_busy};
		end
	end
	assign events = {fire, rx_full, tx_busy == 5'h00};
endmodule : pirfb_periph

/* File: tb/tb_pirfb_bank.sv */
`timescale 1ns/1ns
module tb_pirfb_bank
	import pirfb_pkg::*;
;
	logic          core_clk;
	logic          rst_n;
	logic [31:0]   haddr;
	logic [1:0]    htrans;
	logic          hwrite;
	logic [31:0]   hwdata;
	logic [31:0]   hrdata;
	logic          hreadyout;
	logic          hresp;
	pirfb_events_s events;
	logic [14:2]   fire;
	logic          rx_arrive;
	pirfb_ccmode_e capa_mode;
	pirfb_ccmode_e capb_mode;
	logic          cmp_a;
	logic          cmp_b;
	pirfb_rcause_s rcause;
	logic [7:0]    rx_data_in;
	logic          rx_data_read;
	logic          tx_data_write;
	logic [7:0]    tx_data_out;
	logic          lpw_en;
	logic          sbor_en;
	logic          irq;
	int            miscompares;
	int            checks_done;
	int            ev[11] = '{14, 13, 12, 8, 7, 6, 5, 4, 3, 2, 10};
	logic [7:0]    fa[11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04};
	logic [7:0]    ex[11] = '{8'h11, 8'h12, 8'h14, 8'h18, 8'h18, 8'h18, 8'h80, 8'h10, 8'h08, 8'h04, 8'h01};

	pirfb_bank dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .events(events), .capa_mode(capa_mode),
		.capb_mode(capb_mode), .comparator_a_output(cmp_a), .comparator_b_output(cmp_b),
		.reset_cause_in(rcause), .rx_data_in(rx_data_in), .rx_data_read(rx_data_read),
		.tx_data_write(tx_data_write), .tx_data_out(tx_data_out), .low_power_wake_enable(lpw_en),
		.soft_brownout_enable(sbor_en), .peripheral_irq_req(irq));

	pirfb_periph periph (.core_clk(core_clk), .rst_n(rst_n), .fire(fire), .rx_arrive(rx_arrive),
		.rx_data_read(rx_data_read), .tx_data_write(tx_data_write), .events(events));

	task automatic end_sim();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// one single word transfer; read data is taken at the edge that ends the data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge core_clk);
		haddr  <= {24'h00_0000, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		ahb(1'b0, a, 32'h0000_0000, x);
		chk(x, e);
	endtask : rc

	// the flag lands one edge after the pulse and the request on that same edge
	task automatic pulse(input int i);
		@(posedge core_clk);
		fire[i] <= 1'b1;
		@(posedge core_clk);
		fire[i] <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : pulse

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	initial begin
		repeat (5000) @(posedge core_clk);
		miscompares++;
		end_sim();
	end

	initial begin
		{haddr, htrans, hwrite, hwdata, fire, rx_arrive, cmp_a, cmp_b, rx_data_in} = '0;
		miscompares = 0;
		checks_done = 0;
		rst_n = 1'b0;
		capa_mode = PIRFB_CC_CAPTURE;
		capb_mode = PIRFB_CC_CAPTURE;
		rcause = pirfb_rcause_s'(4'hA);
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		rc(FLAGS_A_ADDR, 32'h0000_0010);
		rc(FLAGS_B_ADDR, 32'h0000_0000);
		chk(32'(sbor_en), 32'h0000_0001);
		rc(POWER_CTL_ADDR, 32'h0000_0010);
		rc(RESET_CAUSE_ADDR, 32'h0000_0005);
		wr(RESET_CAUSE_ADDR, 32'h0000_0001);
		rc(RESET_CAUSE_ADDR, 32'h0000_0004);
		// enables stay zero: each of the eleven pulsed event flags must still rise, the request must not
		for (int i = 0; i < 11; i++) begin
			pulse(ev[i]);
			rc(fa[i], 32'(ex[i]));
			chk(32'(irq), 32'h0000_0000);
			wr(fa[i], 32'h0000_0000);
			rc(fa[i], (fa[i] == FLAGS_A_ADDR) ? 32'h0000_0010 : 32'h0000_0000);
		end
		capa_mode <= PIRFB_CC_COMPARE;
		capb_mode <= PIRFB_CC_PWM;
		pulse(12);
		rc(FLAGS_A_ADDR, 32'h0000_0010);
		pulse(11);
		rc(FLAGS_A_ADDR, 32'h0000_0014);
		pulse(10);
		pulse(9);
		rc(FLAGS_B_ADDR, 32'h0000_0000);
		wr(FLAGS_A_ADDR, 32'h0000_0000);
		cmp_a <= 1'b1;
		cmp_b <= 1'b1;
		repeat (8) @(posedge core_clk);
		rc(FLAGS_B_ADDR, 32'h0000_0060);
		wr(FLAGS_B_ADDR, 32'h0000_00FF);
		rc(FLAGS_B_ADDR, 32'h0000_00FD);
		wr(FLAGS_B_ADDR, 32'h0000_0000);
		wr(ENABLE_B_ADDR, 32'h0000_0080);
		rc(ENABLE_B_ADDR, 32'h0000_0080);
		chk(32'(irq), 32'h0000_0000);
		pulse(5);
		chk(32'(irq), 32'h0000_0001);
		wr(FLAGS_B_ADDR, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h0000_0000);
		rx_data_in <= 8'h5A;
		@(posedge core_clk);
		rx_arrive <= 1'b1;
		@(posedge core_clk);
		rx_arrive <= 1'b0;
		rc(FLAGS_A_ADDR, 32'h0000_0030);
		wr(ENABLE_A_ADDR, 32'h0000_0020);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h0000_0001);
		rc(RX_DATA_ADDR, 32'h0000_005A);
		repeat (2) @(posedge core_clk);
		chk(32'(irq), 32'h0000_0000);
		wr(ENABLE_A_ADDR, 32'h0000_0000);
		rc(FLAGS_A_ADDR, 32'h0000_0010);
		wr(TX_DATA_ADDR, 32'h0000_00A5);
		repeat (2) @(posedge core_clk);
		chk(32'(tx_data_out), 32'h0000_00A5);
		rc(FLAGS_A_ADDR, 32'h0000_0000);
		repeat (20) @(posedge core_clk);
		rc(FLAGS_A_ADDR, 32'h0000_0010);
		wr(POWER_CTL_ADDR, 32'h0000_0020);
		rc(POWER_CTL_ADDR, 32'h0000_0020);
		chk({lpw_en, sbor_en}, 32'h0000_0002);
		wr(8'h40, 32'hFFFF_FFFF);
		rc(8'h40, 32'h0000_0000);
		chk(32'(hresp), 32'h0000_0000);
		end_sim();
	end
endmodule : tb_pirfb_bank
